// [design/nvm_sequencer.v]
// nvm command sequencer: program once and erase commands behind an axi4-lite slave
//
// Operation
// - program once: opcode 07, index five at launch
// - phrase index above seven gives access error
// - blank check, then program, then read-back verify
// - complete flag low until program and verify end
// - already programmed phrase refused with access error
// - all-ones programmed phrase may be programmed again
// - array reads invalid during program once; no violation
// - verify errors set verify and uncorrectable flags
// - erase all: opcode 08, index zero at launch
// - erase all then verify; success releases security
// - erase all refused if any area protected
// - erase block: opcode 09, index one, bit 23
// - bad upper byte access error; protected block violation
// - erase sector: opcode 0A, whole sector erased, verified
// - erase sector misaligned address gives access error
// - protected sector gives violation, no erase
// - command not allowed in mode gives access error
// - clearing complete flag launches; set when finished
`include "nvm_seq_regs.vh"

module nvm_sequencer #(
  parameter [7:0] FLASH_UPPER = 8'h00,  // valid upper address byte of flash block
  parameter [7:0] EEP_UPPER   = 8'h80,  // valid upper address byte of eeprom block
  parameter       SECT_BITS   = 9       // one less than log2 of sector size in bytes
) (
  input  wire        aclk,             // system clock
  input  wire        aresetn,          // synchronous reset, active low
  input  wire [7:0]  s_axi_awaddr,     // write address
  input  wire [2:0]  s_axi_awprot,     // write protection type, unused
  input  wire        s_axi_awvalid,    // write address valid
  output wire        s_axi_awready,    // write address ready
  input  wire [31:0] s_axi_wdata,      // write data
  input  wire [3:0]  s_axi_wstrb,      // write byte strobes
  input  wire        s_axi_wvalid,     // write data valid
  output wire        s_axi_wready,     // write data ready
  output reg  [1:0]  s_axi_bresp,      // write response
  output reg         s_axi_bvalid,     // write response valid
  input  wire        s_axi_bready,     // write response ready
  input  wire [7:0]  s_axi_araddr,     // read address
  input  wire [2:0]  s_axi_arprot,     // read protection type, unused
  input  wire        s_axi_arvalid,    // read address valid
  output wire        s_axi_arready,    // read address ready
  output reg  [31:0] s_axi_rdata,      // read data
  output reg  [1:0]  s_axi_rresp,      // read response
  output reg         s_axi_rvalid,     // read data valid
  input  wire        s_axi_rready,     // read data ready
  output reg         array_req,        // one-cycle array operation request
  output reg  [2:0]  array_op,         // array operation code
  output reg  [23:0] array_addr,       // global address or phrase index
  output reg  [63:0] array_wdata,      // phrase to program
  input  wire        array_done,       // one-cycle array operation done
  input  wire [63:0] array_rdata,      // phrase read back
  input  wire        array_err,        // error seen during verify
  input  wire        array_uncorr,     // non-correctable error seen during verify
  output reg         read_invalid,     // array reads return invalid data
  output reg         secured           // device security state
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;  // waiting for launch
  localparam [2:0] S_CHECK  = 3'h1;  // launch checks
  localparam [2:0] S_BLANK  = 3'h2;  // phrase blank check
  localparam [2:0] S_PGM    = 3'h3;  // phrase program
  localparam [2:0] S_RDBACK = 3'h4;  // phrase read back
  localparam [2:0] S_ERASE  = 3'h5;  // erase in progress
  localparam [2:0] S_EVFY   = 3'h6;  // erase verify

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [15:0] cmd_buf [0:5];          // command_buffer slots
  reg  [2:0]  command_buffer_index;   // slot selector
  reg         command_complete_flag;  // idle when high
  reg         access_error_flag;      // access error, write one to clear
  reg         protection_violation_flag; // protection error, write one to clear
  reg         verify_error_flag;      // error during verify
  reg         verify_uncorrectable_flag; // non-correctable error during verify
  reg  [3:0]  mode_reg;               // commands allowed in current mode
  reg  [15:0] protect_reg;            // protection setup
  reg  [2:0]  state_reg;              // sequencer state
  reg         aw_held;                // write address captured
  reg         w_held;                 // write data captured
  reg  [7:0]  aw_addr_reg;            // captured write address
  reg  [31:0] w_data_reg;             // captured write data
  reg  [3:0]  w_strb_reg;             // captured strobes

  // command fields
  wire [7:0]  opcode    = cmd_buf[0][15:8];           // command code
  wire [23:0] gaddr     = {cmd_buf[0][7:0], cmd_buf[1]}; // global address
  wire        upper_ok  = (gaddr[23:16] == FLASH_UPPER) |
                          (gaddr[23:16] == EEP_UPPER);  // valid block byte
  wire        eep_sel   = gaddr[23];                  // eeprom block chosen
  wire [7:0]  sect_num  = {2'b00, gaddr[15:SECT_BITS+1]}; // flash sector number
  wire        sect_prot = protect_reg[`PROT_SECT_EN] &
                          (sect_num >= protect_reg[`PROT_BOUND_HI:`PROT_BOUND_LO]);
  wire [63:0] pgm_data  = {cmd_buf[2], cmd_buf[3], cmd_buf[4], cmd_buf[5]};

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;  // both halves present
  wire wr_status = do_write & (aw_addr_reg == `OFS_STATUS);
  wire wr_map = (aw_addr_reg == `OFS_STATUS) | (aw_addr_reg == `OFS_INDEX) |
                (aw_addr_reg == `OFS_BUFFER) | (aw_addr_reg == `OFS_MODE) |
                (aw_addr_reg == `OFS_PROTECT) | (aw_addr_reg == `OFS_SECURITY);
  // launch: a one written to the set complete flag
  wire launch = wr_status & w_strb_reg[0] & w_data_reg[`ST_DONE] &
                command_complete_flag;
  wire clr_acc = wr_status & w_strb_reg[0] & w_data_reg[`ST_ACCESS];
  wire clr_pv  = wr_status & w_strb_reg[0] & w_data_reg[`ST_PROTER];
  // setup writes only honoured while idle
  wire wr_cfg  = do_write & command_complete_flag;

  // capture address, data and answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin  // address taken
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin    // data taken
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin                        // perform and answer
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // setup registers and command buffer
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_slot
      // one slot per index, byte lanes honoured
      always @(posedge aclk) begin
        if (!aresetn) begin
          cmd_buf[gi] <= 16'h0000;
        end else if (wr_cfg && aw_addr_reg == `OFS_BUFFER &&
                     command_buffer_index == gi) begin
          if (w_strb_reg[0]) cmd_buf[gi][7:0]  <= w_data_reg[7:0];
          if (w_strb_reg[1]) cmd_buf[gi][15:8] <= w_data_reg[15:8];
        end
      end
    end
  endgenerate

  // index, mode and protection setup
  always @(posedge aclk) begin
    if (!aresetn) begin
      command_buffer_index <= 3'h0;
      mode_reg             <= `MODE_RESET;
      protect_reg          <= `PROTECT_RESET;
    end else if (wr_cfg) begin
      if (aw_addr_reg == `OFS_INDEX && w_strb_reg[0])
        command_buffer_index <= w_data_reg[2:0];
      if (aw_addr_reg == `OFS_MODE && w_strb_reg[0])
        mode_reg <= w_data_reg[3:0];
      if (aw_addr_reg == `OFS_PROTECT) begin
        if (w_strb_reg[0]) protect_reg[7:0]  <= w_data_reg[7:0];
        if (w_strb_reg[1]) protect_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  reg [31:0] rd_mux;  // selected register
  reg        rd_hit;  // address mapped

  // read data select
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_STATUS:   rd_mux = {24'h000000, command_complete_flag, 1'b0,
                               access_error_flag, protection_violation_flag, 2'b00,
                               verify_error_flag, verify_uncorrectable_flag};
      `OFS_INDEX:    rd_mux = {29'h00000000, command_buffer_index};
      `OFS_BUFFER:   rd_mux = (command_buffer_index < 3'h6) ?
                              {16'h0000, cmd_buf[command_buffer_index]} : 32'h00000000;
      `OFS_MODE:     rd_mux = {28'h0000000, mode_reg};
      `OFS_PROTECT:  rd_mux = {16'h0000, protect_reg};
      `OFS_SECURITY: rd_mux = {31'h00000000, secured};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // launch checks
  // ----------------------------------------------------------------
  reg chk_acc;  // access error found at launch
  reg chk_pv;   // protection violation found at launch

  // per command parameter, mode and protection checks
  always @* begin
    chk_acc = 1'b0;
    chk_pv  = 1'b0;
    case (opcode)
      `OPC_PGM_ONCE: begin
        chk_acc = (command_buffer_index != `IDX_PGM_ONCE) |
                  ~mode_reg[`MODE_PGM_ONCE] |
                  (cmd_buf[1] > `PHRASE_MAX);
      end                                                           // never a violation
      `OPC_ERS_ALL: begin
        chk_acc = (command_buffer_index != `IDX_ERS_ALL) |
                  ~mode_reg[`MODE_ERS_ALL];
        chk_pv  = protect_reg[`PROT_FLASH_ANY] | protect_reg[`PROT_EEP_ANY] |
                  protect_reg[`PROT_SECT_EN];
      end
      `OPC_ERS_BLK: begin
        chk_acc = (command_buffer_index != `IDX_ERS_ADDR) |
                  ~mode_reg[`MODE_ERS_BLK] | ~upper_ok;
        chk_pv  = eep_sel ? protect_reg[`PROT_EEP_ANY] :
                  (protect_reg[`PROT_FLASH_ANY] | protect_reg[`PROT_SECT_EN]);
      end
      `OPC_ERS_SECT: begin
        chk_acc = (command_buffer_index != `IDX_ERS_ADDR) |
                  ~mode_reg[`MODE_ERS_SECT] | ~upper_ok |
                  (gaddr[1:0] != 2'b00);
        chk_pv  = eep_sel ? protect_reg[`PROT_EEP_ANY] :
                  (protect_reg[`PROT_FLASH_ANY] | sect_prot);
      end
      default: chk_acc = 1'b1;  // command outside this sequencer
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire blank_ok   = (array_rdata == `ERASED_PHRASE);
  wire rdback_bad = (array_rdata != pgm_data) | array_err;

  // array handshake and status flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg                 <= S_IDLE;
      command_complete_flag     <= 1'b1;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag         <= 1'b0;
      verify_uncorrectable_flag <= 1'b0;
      array_req                 <= 1'b0;
      array_op                  <= `AOP_READ_OTP;
      array_addr                <= 24'h000000;
      array_wdata               <= 64'h0000000000000000;
      read_invalid              <= 1'b0;
      secured                   <= `SECURE_RESET;
    end else begin
      array_req <= 1'b0;
      // software clears access and violation flags; a set below wins
      if (clr_acc) access_error_flag <= 1'b0;
      if (clr_pv)  protection_violation_flag <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (launch) begin
            command_complete_flag     <= 1'b0;
            verify_error_flag         <= 1'b0;
            verify_uncorrectable_flag <= 1'b0;
            state_reg                 <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (chk_acc | chk_pv) begin
            if (chk_acc) access_error_flag <= 1'b1;
            else protection_violation_flag <= 1'b1;
            command_complete_flag <= 1'b1;
            state_reg             <= S_IDLE;
          end else begin
            array_req  <= 1'b1;
            array_addr <= gaddr;
            case (opcode)
              `OPC_PGM_ONCE: begin
                array_op     <= `AOP_READ_OTP;
                array_addr   <= {8'h00, cmd_buf[1]};
                read_invalid <= 1'b1;
                state_reg    <= S_BLANK;
              end
              `OPC_ERS_ALL: begin
                array_op  <= `AOP_ERS_ALL;
                state_reg <= S_ERASE;
              end
              `OPC_ERS_BLK: begin
                array_op  <= `AOP_ERS_BLK;
                state_reg <= S_ERASE;
              end
              default: begin
                array_op  <= `AOP_ERS_SECT;
                state_reg <= S_ERASE;
              end
            endcase
          end
        end
        S_BLANK: begin
          if (array_done) begin
            if (blank_ok) begin
              array_req   <= 1'b1;
              array_op    <= `AOP_PGM_OTP;
              array_wdata <= pgm_data;
              state_reg   <= S_PGM;
            end else begin
              access_error_flag     <= 1'b1;
              read_invalid          <= 1'b0;
              command_complete_flag <= 1'b1;
              state_reg             <= S_IDLE;
            end
          end
        end
        S_PGM: begin
          if (array_done) begin
            array_req <= 1'b1;
            array_op  <= `AOP_READ_OTP;
            state_reg <= S_RDBACK;
          end
        end
        S_RDBACK: begin
          if (array_done) begin
            if (rdback_bad) verify_error_flag <= 1'b1;
            if (array_uncorr) verify_uncorrectable_flag <= 1'b1;
            read_invalid          <= 1'b0;
            command_complete_flag <= 1'b1;
            state_reg             <= S_IDLE;
          end
        end
        S_ERASE: begin
          if (array_done) begin
            array_req <= 1'b1;
            array_op  <= (opcode == `OPC_ERS_ALL) ? `AOP_VFY_ALL :
                         (opcode == `OPC_ERS_BLK) ? `AOP_VFY_BLK : `AOP_VFY_SECT;
            state_reg <= S_EVFY;
          end
        end
        S_EVFY: begin
          if (array_done) begin
            if (array_err) verify_error_flag <= 1'b1;
            if (array_uncorr) verify_uncorrectable_flag <= 1'b1;
            if (opcode == `OPC_ERS_ALL && !array_err && !array_uncorr)
              secured <= 1'b0;
            command_complete_flag <= 1'b1;
            state_reg             <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // nvm_sequencer

// [design/nvm_seq_regs.vh]
// register offsets, field positions, reset values and codes of the nvm command sequencer
`ifndef NVM_SEQ_REGS_VH
`define NVM_SEQ_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_STATUS      8'h00
`define OFS_INDEX       8'h04
`define OFS_BUFFER      8'h08
`define OFS_MODE        8'h0C
`define OFS_PROTECT     8'h10
`define OFS_SECURITY    8'h14

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ST_DONE         7
`define ST_ACCESS       5
`define ST_PROTER       4
`define ST_VERR         1
`define ST_VUNC         0

// ----------------------------------------------------------------
// mode and protect register fields
// ----------------------------------------------------------------
`define MODE_PGM_ONCE   0
`define MODE_ERS_ALL    1
`define MODE_ERS_BLK    2
`define MODE_ERS_SECT   3
`define PROT_FLASH_ANY  0
`define PROT_EEP_ANY    1
`define PROT_SECT_EN    2
`define PROT_BOUND_HI   15
`define PROT_BOUND_LO   8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MODE_RESET      4'hF
`define PROTECT_RESET   16'h0000
`define SECURE_RESET    1'b1

// ----------------------------------------------------------------
// command opcodes and launch index
// ----------------------------------------------------------------
`define OPC_PGM_ONCE    8'h07
`define OPC_ERS_ALL     8'h08
`define OPC_ERS_BLK     8'h09
`define OPC_ERS_SECT    8'h0A
`define IDX_PGM_ONCE    3'h5
`define IDX_ERS_ALL     3'h0
`define IDX_ERS_ADDR    3'h1
`define PHRASE_MAX      16'h0007
`define ERASED_PHRASE   64'hFFFFFFFFFFFFFFFF

// ----------------------------------------------------------------
// array operation codes
// ----------------------------------------------------------------
`define AOP_READ_OTP    3'h0
`define AOP_PGM_OTP     3'h1
`define AOP_ERS_ALL     3'h2
`define AOP_ERS_BLK     3'h3
`define AOP_ERS_SECT    3'h4
`define AOP_VFY_ALL     3'h5
`define AOP_VFY_BLK     3'h6
`define AOP_VFY_SECT    3'h7

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [testbench/nvm_seq_props.sv]
// assertions on the array side of the nvm sequencer
`include "nvm_seq_regs.vh"
module nvm_seq_props (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, low
  input wire logic        array_req,     // op request
  input wire logic [2:0]  array_op,      // op code
  input wire logic [23:0] array_addr,    // address
  input wire logic        array_done,    // op done
  input wire logic [63:0] array_rdata,   // read data
  input wire logic        array_err,     // verify error
  input wire logic        array_uncorr,  // uncorrectable
  input wire logic        read_invalid,  // reads invalid
  input wire logic        secured        // security state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_req_one_cycle: assert property (array_req |=> !array_req)
    else $error("request pulse too long");
  a_blank_then_prog: assert property (array_req && array_op == `AOP_PGM_OTP |->
    $past(array_done) && $past(array_op) == `AOP_READ_OTP && $past(array_rdata) == `ERASED_PHRASE)
    else $error("program without blank check");
  a_used_refused: assert property (array_done && array_op == `AOP_READ_OTP &&
    array_rdata != `ERASED_PHRASE |=> !array_req) else $error("used phrase programmed");
  a_erase_then_vfy: assert property (array_done && array_op inside {3'h2, 3'h3, 3'h4}
    |=> array_req && array_op == $past(array_op) + 3'h3) else $error("verify missing");
  a_vfy_after_ers: assert property (array_req && array_op >= `AOP_VFY_ALL |->
    $past(array_done) && $past(array_op) == array_op - 3'h3) else $error("early verify");
  a_phrase_range: assert property (array_req && array_op <= `AOP_PGM_OTP |->
    array_addr[15:0] <= `PHRASE_MAX) else $error("phrase index out of range");
  a_invalid_reads: assert property (array_req && array_op == `AOP_PGM_OTP |-> read_invalid)
    else $error("reads valid while programming");
  a_unsecure_ok: assert property ($fell(secured) |-> $past(array_done) &&
    $past(array_op) == `AOP_VFY_ALL && !$past(array_err) && !$past(array_uncorr))
    else $error("security released wrongly");
endmodule // nvm_seq_props

// [testbench/nvm_array_model.sv]
// behavioural model of the nvm array behind the sequencer
module nvm_array_model (
  input  wire logic        aclk,          // clock
  input  wire logic        aresetn,       // reset, low
  input  wire logic        array_req,     // op request
  input  wire logic [2:0]  array_op,      // op code
  input  wire logic [23:0] array_addr,    // phrase index
  input  wire logic [63:0] array_wdata,   // phrase data
  input  wire logic        slow,          // long op time
  input  wire logic        inj_err,       // verify error
  input  wire logic        inj_unc,       // uncorrectable
  output logic             array_done,    // done pulse
  output logic      [63:0] array_rdata,   // read data
  output logic             array_err,     // verify error
  output logic             array_uncorr   // uncorrectable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] otp [0:7];  // one-time phrases
  logic [3:0]  cnt;        // wait counter
  logic        busy;       // op in flight
  logic [2:0]  op, ph;     // op and phrase held
  initial begin
    busy = 1'b0;
    array_rdata = '0;
    for (int i = 0; i < 8; i++) otp[i] = '1;
  end
  // one op at a time; data changes every cycle outside done
  always @(posedge aclk) begin
    array_done <= 1'b0;
    array_err <= 1'b0;
    array_uncorr <= 1'b0;
    array_rdata <= ~array_rdata;
    if (!aresetn) busy <= 1'b0;
    else if (array_req) begin
      busy <= 1'b1;
      cnt <= slow ? 4'h9 : 4'h1;
      op <= array_op;
      ph <= array_addr[2:0];
      if (array_op == 3'h1) otp[array_addr[2:0]] <= array_wdata;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      array_done <= 1'b1;
      array_rdata <= otp[ph];
      array_err <= inj_err && op >= 3'h5;
      array_uncorr <= inj_unc && op >= 3'h5;
    end else if (busy) cnt <= cnt - 4'h1;
  end
endmodule // nvm_array_model

// [testbench/testbench.sv]
// self-checking testbench of the nvm command sequencer
`include "nvm_seq_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, slow = 0, inj_err = 0, inj_unc = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdd, st;
  logic [1:0] bresp, rresp, rs;
  logic awr, wr_rdy, bv, arr, rv, array_req, array_done, array_err, array_uncorr;
  logic [2:0] array_op;
  logic [23:0] array_addr;
  logic [63:0] array_wdata, array_rdata, d;
  int n_fail = 0, tests_run = 0, cyc = 0, seed = 32'h521d;
  always #50 aclk = ~aclk;
  nvm_sequencer nvm_sequencer_inst (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .array_req, .array_op, .array_addr, .array_wdata, .array_done,
    .array_rdata, .array_err, .array_uncorr, .read_invalid(), .secured());
  nvm_array_model nvm_array_model_inst (.aclk, .aresetn, .array_req, .array_op, .array_addr,
    .array_wdata, .slow, .inj_err, .inj_unc, .array_done, .array_rdata, .array_err,
    .array_uncorr);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    rs = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= a; arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    st = rdd; rs = rresp;
  endtask
  // status expected: access error outranks violation
  function automatic logic [7:0] ex(input logic acc, pv, ve, vu);
    return {2'b10, acc, !acc && pv, 2'b00, ve, vu};
  endfunction
  // load slots, launch, poll with reads only
  task automatic cmd(input logic [15:0] s0, s1, input logic [2:0] ix, input logic [7:0] e);
    wr(`OFS_STATUS, 32'h30);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_INDEX, 32'(i));
      wr(`OFS_BUFFER, i == 0 ? s0 : i == 1 ? s1 : d[(5 - i) * 16 +: 16]);
    end
    wr(`OFS_INDEX, 32'(ix));
    wr(`OFS_STATUS, 32'h80);
    rd(`OFS_STATUS);
    if (slow) `CHK(st[7], 1'b0)
    while (!st[7]) rd(`OFS_STATUS);
    `CHK(st[7:0], e)
    $display("command %h ended, status %h", s0, st[7:0]);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_STATUS); `CHK(st[7:0], 8'h80)
    rd(8'h40); `CHK(rs, `RESP_SLVERR)
    for (int p = 0; p < 8; p++) begin
      d = {$random(seed), $random(seed)};
      if (p == 3) d = `ERASED_PHRASE;
      slow <= p[0];
      cmd({`OPC_PGM_ONCE, 8'h00}, 16'(p), `IDX_PGM_ONCE, ex(0, 0, 0, 0));
    end
    slow <= 1'b0;
    for (int p = 0; p < 8; p++)
      cmd({`OPC_PGM_ONCE, 8'h00}, 16'(p), `IDX_PGM_ONCE, ex(p != 3, 0, 0, 0));
    cmd({`OPC_PGM_ONCE, 8'h00}, 16'h8 + 16'($random(seed) & 8'hFF), 3'h5, ex(1, 0, 0, 0));
    cmd({`OPC_PGM_ONCE, 8'h00}, 16'h0, 3'h4, ex(1, 0, 0, 0));
    wr(`OFS_MODE, 32'h0);
    for (int k = 0; k < 4; k++)
      cmd({`OPC_PGM_ONCE + 8'(k), 8'h00}, 16'h0, k ? 3'(k > 1) : 3'h5, ex(1, 0, 0, 0));
    wr(`OFS_MODE, 32'hF);
    wr(`OFS_PROTECT, 32'h1 << ($random(seed) & 1));
    cmd({`OPC_ERS_ALL, 8'h00}, 16'h0, `IDX_ERS_ALL, ex(0, 1, 0, 0));
    wr(`OFS_PROTECT, 32'h0);
    cmd({`OPC_ERS_ALL, 8'h00}, 16'h0, 3'h1, ex(1, 0, 0, 0));
    inj_err <= 1'b1;
    cmd({`OPC_ERS_ALL, 8'h00}, 16'h0, `IDX_ERS_ALL, ex(0, 0, 1, 0));
    rd(`OFS_SECURITY); `CHK(st[0], 1'b1)
    inj_err <= 1'b0;
    cmd({`OPC_ERS_ALL, 8'h00}, 16'h0, `IDX_ERS_ALL, ex(0, 0, 0, 0));
    rd(`OFS_SECURITY); `CHK(st[0], 1'b0)
    wr(`OFS_PROTECT, 32'h2);
    cmd({`OPC_ERS_BLK, 8'h80}, 16'($random(seed)), 3'h1, ex(0, 1, 0, 0));
    cmd({`OPC_ERS_BLK, 8'h42}, 16'h0, 3'h1, ex(1, 0, 0, 0));
    inj_unc <= 1'b1;
    cmd({`OPC_ERS_BLK, 8'h00}, 16'h0, 3'h1, ex(0, 0, 0, 1));
    inj_unc <= 1'b0;
    wr(`OFS_PROTECT, 32'h4);
    cmd({`OPC_ERS_SECT, 8'h00}, 16'h0400, 3'h1, ex(0, 1, 0, 0));
    cmd({`OPC_ERS_SECT, 8'h00}, 16'h0402, 3'h1, ex(1, 0, 0, 0));
    wr(`OFS_PROTECT, 32'h3F04);
    cmd({`OPC_ERS_SECT, 8'h00}, 16'($random(seed)) & 16'h7FFC, 3'h1, ex(0, 0, 0, 0));
    end_of_test;
  end
endmodule // testbench
bind nvm_sequencer nvm_seq_props nvm_seq_props_inst (.aclk, .aresetn, .array_req, .array_op,
  .array_addr, .array_done, .array_rdata, .array_err, .array_uncorr, .read_invalid, .secured);
